// ---- ams_pkg.sv ----
// Constants and types for the asynchronous memory strobe sequencer
package ams_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int READY_HOLD_NS = 2 * CLK_PERIOD_NS;
  localparam int READY_HOLD_CYC = (READY_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // Port geometry
  localparam int WIDE_DATA_W = 64;
  localparam int WIDE_BE_W = 8;
  localparam int WIDE_ADDR_MSB = 22;
  localparam int WIDE_ADDR_LSB = 3;
  localparam int NARROW_DATA_W = 16;
  localparam int NARROW_BE_W = 2;
  localparam int NARROW_ADDR_MSB = 20;
  localparam int NARROW_ADDR_LSB = 1;
  localparam int NUM_CE = 4;

  // ==========================================================
  // Phase counter
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
  localparam logic [CNT_W-1:0] READY_SAMPLE_REM = 6'h02;
  localparam int LEN_W = 8;

  // ==========================================================
  // Register map
  localparam int AVS_ADDR_W = 5;
  localparam logic [AVS_ADDR_W-1:0] REG_TIMING_BASE = 5'h00;
  localparam logic [AVS_ADDR_W-1:0] REG_STATUS = 5'h10;
  localparam logic [31:0] TIMING_RST = 32'hfffb_ff07;
  localparam logic [31:0] TIMING_MASK = 32'hfffb_ff07;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_PHASE_LSB = 1;
  localparam int ST_WRITE_BIT = 3;
  localparam int ST_READY_BIT = 4;

  // Timing word, bit 31 first; rsv fields read as zero
  typedef struct packed {
    logic [3:0] ws;
    logic [5:0] write_pulse_cycles;
    logic [2:0] wh;
    logic rsv_hi;
    logic [3:0] rs;
    logic [5:0] rst;
    logic [4:0] rsv_lo;
    logic [2:0] rh;
  } ams_timing_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SETUP = 2'b01,
    ST_STROBE = 2'b10,
    ST_HOLD = 2'b11
  } ams_state_t;

endpackage

// ---- ams_sync.sv ----
// Two-flop synchroniser for the memory ready input
module ams_sync (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Data
  input wire logic async_i,
  output logic sync_o
);

  // ==========================================================
  // Chain
  logic meta_q;
  logic sync_q;

  // Reset high so an idle memory reads as ready
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule

// ---- ams_phase_cnt.sv ----
// Down counter that times one access phase
module ams_phase_cnt #(
  parameter int W = 6
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Control
  input wire logic load_i,
  input wire logic [W-1:0] load_val_i,
  input wire logic freeze_i,
  output logic [W-1:0] count_o
);

  // ==========================================================
  // Counter
  logic [W-1:0] count_q;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count_q <= '0;
    end else if (load_i) begin
      count_q <= load_val_i;
    end else if (!freeze_i && count_q != '0) begin
      count_q <= count_q - 1'b1;
    end
  end

  assign count_o = count_q;

endmodule

// ---- ams_seq.sv ----
// Asynchronous memory access sequencer with Avalon-MM timing registers
// Overview of operation
// [RL1] Ready input passes a two-flop synchroniser
// [RL2] Ready looked at two cycles before end
// [RL3] Ready low stretches strobe one cycle each
// [RL4] Strobe ends two cycles after ready high
// [RL5] Memory holds each ready level two periods
// [RL6] Software sizes strobe to cover access time
// [RL7] Read selects valid setup cycles before strobe
// [RL8] Read selects held hold cycles after strobe
// [RL9] Write selects, data valid setup cycles before
// [RL10] Write selects, data held hold cycles after
// [RL11] Six timing counts per chip select
// [RL12] All phases counted in memory clock periods
// [RL13] Strobes change only on rising clock edges
// [RL14] Ready sampled on rising clock edges
// [RL15] Read data captured as strobe rises
// [RL16] Wide port: eight lanes, address 22:3
// [RL17] Narrow port: two lanes, address 20:1
// [RL18] Strobe pins carry only asynchronous meanings
// [RL19] Setup, strobe, hold in order, selects stable
// [RL20] Every count treated as one at least
module ams_seq
  import ams_pkg::*;
#(
  parameter int DATA_W = WIDE_DATA_W,
  parameter int BE_W = WIDE_BE_W,
  parameter int ADDR_MSB = WIDE_ADDR_MSB,
  parameter int ADDR_LSB = WIDE_ADDR_LSB,
  parameter int NUM_CE_P = NUM_CE
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Avalon-MM slave
  input wire logic [AVS_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Access requests
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [$clog2(NUM_CE_P)-1:0] req_ce_i,
  input wire logic [ADDR_MSB:ADDR_LSB] req_addr_i,
  input wire logic [BE_W-1:0] req_be_i,
  input wire logic [DATA_W-1:0] req_wdata_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic [DATA_W-1:0] rsp_rdata_o,
  // Memory pins
  output logic [NUM_CE_P-1:0] chip_select_n_o,
  output logic [BE_W-1:0] byte_lane_n_o,
  output logic [ADDR_MSB:ADDR_LSB] mem_addr_bus_o,
  output logic [DATA_W-1:0] mem_data_bus_o,
  output logic mem_data_oe_o,
  input wire logic [DATA_W-1:0] mem_data_bus_i,
  output logic output_gate_n_o,
  output logic read_strobe_n_o,
  output logic write_strobe_n_o,
  input wire logic wait_ready_in_i
);

  localparam int CE_W = $clog2(NUM_CE_P);

  // ==========================================================
  // Decoding
  function automatic logic [CNT_W-1:0] phase_cycles(ams_timing_t t, logic wr,
                                                    ams_state_t ph);
    logic [CNT_W-1:0] n;
    n = '0;
    unique case (ph)
      ST_IDLE: n = '0;
      ST_SETUP: n = wr ? {2'h0, t.ws} : {2'h0, t.rs};
      ST_STROBE: n = wr ? t.write_pulse_cycles : t.rst;
      ST_HOLD: n = wr ? {3'h0, t.wh} : {3'h0, t.rh};
    endcase
    // A zero count would never leave the phase
    phase_cycles = (n == '0) ? CNT_ONE : n; // RL20
  endfunction

  // ==========================================================
  // Declarations
  logic [31:0] timing_q [NUM_CE_P];
  logic [31:0] rdata_q;
  logic wait_q;
  ams_state_t state_q;
  ams_state_t state_d;
  ams_timing_t cfg_q;
  ams_timing_t req_cfg;
  logic wr_q;
  logic ready_q;
  logic rsp_q;
  logic [DATA_W-1:0] mem_rdata_q;
  logic [NUM_CE_P-1:0] cs_n_q;
  logic [BE_W-1:0] be_n_q;
  logic [ADDR_MSB:ADDR_LSB] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic oe_q;
  logic gate_n_q;
  logic rd_stb_n_q;
  logic wr_stb_n_q;
  logic rdy_s;
  logic accept;
  logic cnt_load;
  logic cnt_freeze;
  logic [CNT_W-1:0] cnt_val;
  logic [CNT_W-1:0] cnt;
  logic [2:0] avs_idx;
  logic avs_hit_timing;

  // ==========================================================
  // Register bus
  assign avs_idx = avs_address_i[4:2];
  assign avs_hit_timing = (avs_address_i[4] == REG_TIMING_BASE[4]) &&
                          (avs_address_i[1:0] == 2'h0) &&
                          (32'(avs_idx) < NUM_CE_P);

  // One wait cycle per access; the answer lands in the following cycle
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wait_q <= 1'b1;
    end else if ((avs_read_i || avs_write_i) && wait_q) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read_i && wait_q) begin
      if (avs_hit_timing) begin
        rdata_q <= timing_q[avs_idx[CE_W-1:0]] & TIMING_MASK;
      end else if (avs_address_i == REG_STATUS) begin
        rdata_q <= '0;
        rdata_q[ST_BUSY_BIT] <= state_q != ST_IDLE;
        rdata_q[ST_PHASE_LSB +: 2] <= state_q;
        rdata_q[ST_WRITE_BIT] <= wr_q;
        rdata_q[ST_READY_BIT] <= rdy_s;
      end else begin
        rdata_q <= 32'h0000_0000;
      end
    end
  end

  // Timing words change on a completed bus write to their own address, even on the edge where an access latches them
  for (genvar g = 0; g < NUM_CE_P; g++) begin : g_timing
    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        timing_q[g] <= TIMING_RST;
      end else if (avs_write_i && !wait_q && avs_hit_timing &&
                   32'(avs_idx) == g) begin // RL11
        for (int b = 0; b < 4; b++) begin
          if (avs_byteenable_i[b]) begin
            timing_q[g][8*b +: 8] <= avs_writedata_i[8*b +: 8] & TIMING_MASK[8*b +: 8];
          end
        end
      end
    end
  end

  assign avs_readdata_o = rdata_q;
  assign avs_waitrequest_o = wait_q;

  // ==========================================================
  // Ready input
  ams_sync u_sync (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .async_i(wait_ready_in_i), // RL1 RL14
    .sync_o(rdy_s)
  );

  // ==========================================================
  // Phase sequencing
  assign accept = req_valid_i && ready_q;
  assign req_cfg = ams_timing_t'(timing_q[req_ce_i]);

  always_comb begin
    state_d = state_q;
    cnt_load = 1'b0;
    cnt_freeze = 1'b0;
    cnt_val = '0;
    unique case (state_q)
      ST_IDLE: begin
        if (accept) begin
          state_d = ST_SETUP;
          cnt_load = 1'b1;
          cnt_val = phase_cycles(req_cfg, req_write_i, ST_SETUP); // RL7 RL9
        end
      end
      ST_SETUP: begin
        if (cnt == CNT_ONE) begin
          state_d = ST_STROBE; // RL19
          cnt_load = 1'b1;
          cnt_val = phase_cycles(cfg_q, wr_q, ST_STROBE); // RL12
        end
      end
      ST_STROBE: begin
        // Earlier strobe cycles never look at ready
        if (cnt == READY_SAMPLE_REM && !rdy_s) begin // RL2
          cnt_freeze = 1'b1; // RL3
        end else if (cnt == CNT_ONE) begin // RL4
          state_d = ST_HOLD;
          cnt_load = 1'b1;
          cnt_val = phase_cycles(cfg_q, wr_q, ST_HOLD); // RL8 RL10
        end
      end
      ST_HOLD: begin
        if (cnt == CNT_ONE) begin
          state_d = ST_IDLE;
        end
      end
    endcase
  end

  ams_phase_cnt #(
    .W(CNT_W)
  ) u_cnt (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .load_i(cnt_load),
    .load_val_i(cnt_val),
    .freeze_i(cnt_freeze),
    .count_o(cnt)
  );

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= ST_IDLE;
      ready_q <= 1'b1;
      rsp_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ready_q <= state_d == ST_IDLE;
      rsp_q <= state_q == ST_HOLD && state_d == ST_IDLE;
    end
  end

  // Timing is latched per access so a register write mid-access is safe
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg_q <= ams_timing_t'(TIMING_RST);
      wr_q <= 1'b0;
    end else if (accept) begin
      cfg_q <= req_cfg;
      wr_q <= req_write_i;
    end
  end

  // ==========================================================
  // Select group
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cs_n_q <= '1;
      be_n_q <= '1;
      addr_q <= '0;
      wdata_q <= '0;
      oe_q <= 1'b0;
      gate_n_q <= 1'b1;
    end else if (accept) begin // RL16 RL17
      cs_n_q <= ~(NUM_CE_P'(1) << req_ce_i);
      be_n_q <= ~req_be_i;
      addr_q <= req_addr_i;
      wdata_q <= req_wdata_i;
      oe_q <= req_write_i;
      gate_n_q <= req_write_i;
    end else if (state_q == ST_HOLD && state_d == ST_IDLE) begin // RL19
      cs_n_q <= '1;
      be_n_q <= '1;
      oe_q <= 1'b0;
      gate_n_q <= 1'b1;
    end
  end

  // Strobes are pure flops; the pins have no synchronous meaning here
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_stb_n_q <= 1'b1;
      wr_stb_n_q <= 1'b1;
    end else begin
      rd_stb_n_q <= !(state_d == ST_STROBE && !wr_q); // RL13 RL18
      wr_stb_n_q <= !(state_d == ST_STROBE && wr_q); // RL13 RL18
    end
  end

  // ==========================================================
  // Read data
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mem_rdata_q <= '0;
    end else if (state_q == ST_STROBE && state_d == ST_HOLD && !wr_q) begin
      mem_rdata_q <= mem_data_bus_i; // RL15
    end
  end

  assign req_ready_o = ready_q;
  assign rsp_valid_o = rsp_q;
  assign rsp_rdata_o = mem_rdata_q;
  assign chip_select_n_o = cs_n_q;
  assign byte_lane_n_o = be_n_q;
  assign mem_addr_bus_o = addr_q;
  assign mem_data_bus_o = wdata_q;
  assign mem_data_oe_o = oe_q;
  assign output_gate_n_o = gate_n_q;
  assign read_strobe_n_o = rd_stb_n_q;
  assign write_strobe_n_o = wr_stb_n_q;

  // ==========================================================
  // Checks
  logic [1:0] live_q;
  logic [LEN_W-1:0] len_q;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      live_q <= 2'h0;
      len_q <= '0;
    end else begin
      live_q <= {live_q[0], 1'b1};
      if (state_d != state_q) begin
        len_q <= LEN_W'(1);
      end else if (len_q != '1) begin
        len_q <= len_q + 1'b1;
      end
    end
  end

  a_ready_sync_path: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RL1
    live_q[1] |-> rdy_s == $past(wait_ready_in_i, 2))
    else $error("ready synchroniser is not two stages");

  a_ready_early_ignored: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RL2
    state_q == ST_STROBE && cnt > READY_SAMPLE_REM |=> cnt == $past(cnt) - 1'b1)
    else $error("strobe count stalled before the ready point");

  a_ready_stretch: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RL3
    state_q == ST_STROBE && cnt == READY_SAMPLE_REM && !rdy_s
    |=> state_q == ST_STROBE && cnt == READY_SAMPLE_REM)
    else $error("strobe not stretched while ready low");

  a_ready_release: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RL4
    state_q == ST_STROBE && cnt == READY_SAMPLE_REM && rdy_s
    |=> state_q == ST_STROBE ##1 read_strobe_n_o && write_strobe_n_o)
    else $error("strobe did not end two cycles after ready");

  a_read_setup_len: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RL7
    $fell(read_strobe_n_o) |->
      $past(len_q) == LEN_W'(phase_cycles(cfg_q, 1'b0, ST_SETUP)) && !output_gate_n_o)
    else $error("read setup length wrong");

  a_read_hold_len: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RL8
    $past(state_q) == ST_HOLD && state_q == ST_IDLE && !wr_q |->
      $past(len_q) == LEN_W'(phase_cycles(cfg_q, 1'b0, ST_HOLD)) && &chip_select_n_o)
    else $error("read hold length wrong");

  a_write_setup_len: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RL9
    $fell(write_strobe_n_o) |->
      $past(len_q) == LEN_W'(phase_cycles(cfg_q, 1'b1, ST_SETUP)) && mem_data_oe_o)
    else $error("write setup length wrong");

  a_write_hold_len: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RL10
    $past(state_q) == ST_HOLD && state_q == ST_IDLE && wr_q |->
      $past(len_q) == LEN_W'(phase_cycles(cfg_q, 1'b1, ST_HOLD)) && !mem_data_oe_o)
    else $error("write hold length wrong");

  a_select_stable: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RL19
    state_q != ST_IDLE && $past(state_q) != ST_IDLE |->
      $stable(mem_addr_bus_o) && $stable(chip_select_n_o) && $stable(mem_data_bus_o))
    else $error("select group moved during an access");

  a_read_capture: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RL15
    $rose(read_strobe_n_o) |-> rsp_rdata_o == $past(mem_data_bus_i))
    else $error("read data not captured at strobe rise");

endmodule

// ---- ams_mem_model.sv ----
// Behavioural asynchronous memory with a stretchable ready line
module ams_mem_model #(
  parameter int DW = 64,
  parameter int AW = 20
) (
  // Clock
  input wire logic clk_i,
  // Memory pins
  input wire logic cs_n_i,
  input wire logic [DW/8-1:0] lane_n_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic gate_n_i,
  input wire logic wr_n_i,
  output logic [DW-1:0] rdata_o,
  output logic ready_o,
  // Not-ready span in cycles from select, zero or at least two
  input wire logic [7:0] slow_i
);
  logic [DW-1:0] mem [logic [AW-1:0]];
  logic [DW-1:0] last_q = '0;
  int cnt_q = 0;
  // ==========================================================
  // Ready held low from select for the whole span, never a one-cycle blip
  always @(posedge clk_i) cnt_q <= cs_n_i ? 0 : cnt_q + 1;
  assign ready_o = cs_n_i || (cnt_q >= int'(slow_i));
  // ==========================================================
  // Storage, written at the strobe's rising edge, lane by lane
  always @(posedge wr_n_i) begin
    logic [DW-1:0] w;
    // Skip the strobe edge that reset makes while the address is still unknown
    if (cs_n_i === 1'b0) begin
      w = mem.exists(addr_i) ? mem[addr_i] : '0;
      for (int i = 0; i < DW / 8; i++) if (!lane_n_i[i]) w[8*i +: 8] = wdata_i[8*i +: 8];
      mem[addr_i] = w;
    end
  end
  // Data driven from select on, so only the strobe count bounds access time
  always @* begin
    if (!cs_n_i && !gate_n_i && wr_n_i) rdata_o = mem.exists(addr_i) ? mem[addr_i] : '0;
    else rdata_o = ~last_q;
  end
  // Released bus keeps changing so a stale capture cannot pass by luck
  always @(posedge clk_i) last_q <= rdata_o;
endmodule

// ---- tb_top.sv ----
// Self-checking testbench for the asynchronous memory strobe sequencer
module tb_top
  import ams_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Signals
  logic clk_i = 1'b0, arst_n_i = 1'b0;
  logic [4:0] avs_address_i = '0;
  logic avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = '0, avs_readdata_o;
  logic avs_waitrequest_o, req_valid_i = 1'b0, req_write_i = 1'b0, req_ready_o, rsp_valid_o;
  logic [1:0] req_ce_i = '0;
  logic [22:3] req_addr_i = '0, mem_addr_bus_o;
  logic [7:0] req_be_i = '0, byte_lane_n_o, slow = '0;
  logic [63:0] req_wdata_i = '0, rsp_rdata_o, mem_data_bus_o, mem_data_bus_i;
  logic [3:0] chip_select_n_o;
  logic mem_data_oe_o, output_gate_n_o, read_strobe_n_o, write_strobe_n_o, wait_ready_in_i;
  logic wait_s;
  logic [31:0] rdat_s;
  int err_total = 0, checks_done = 0;
  int tset[2][4], tlen[2][4], thld[2][4];
  logic [63:0] shadow [logic [19:0]];

  ams_seq DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(4'hf), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .req_valid_i(req_valid_i),
    .req_write_i(req_write_i), .req_ce_i(req_ce_i), .req_addr_i(req_addr_i),
    .req_be_i(req_be_i), .req_wdata_i(req_wdata_i), .req_ready_o(req_ready_o),
    .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o), .chip_select_n_o(chip_select_n_o),
    .byte_lane_n_o(byte_lane_n_o), .mem_addr_bus_o(mem_addr_bus_o),
    .mem_data_bus_o(mem_data_bus_o), .mem_data_oe_o(mem_data_oe_o),
    .mem_data_bus_i(mem_data_bus_i), .output_gate_n_o(output_gate_n_o),
    .read_strobe_n_o(read_strobe_n_o), .write_strobe_n_o(write_strobe_n_o),
    .wait_ready_in_i(wait_ready_in_i));

  ams_mem_model u_mem (.clk_i(clk_i), .cs_n_i(&chip_select_n_o), .lane_n_i(byte_lane_n_o),
    .addr_i(mem_addr_bus_o), .wdata_i(mem_data_bus_o), .gate_n_i(output_gate_n_o),
    .wr_n_i(write_strobe_n_o), .rdata_o(mem_data_bus_i), .ready_o(wait_ready_in_i),
    .slow_i(slow));

  initial forever #4 clk_i = ~clk_i;
  // Mid-cycle snapshot equals what the next rising edge samples
  always @(negedge clk_i) begin
    wait_s = avs_waitrequest_o;
    rdat_s = avs_readdata_o;
  end
  // ==========================================================
  // Shared tasks
  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t ns: %s, seen %h, expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("Checks made: %0d, errors: %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic avs(input bit wr, input logic [4:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int g;
    g = 0;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    avs_writedata_i <= wd;
    do begin
      @(posedge clk_i);
      g++;
    end while (wait_s !== 1'b0 && g < 50);
    rd = rdat_s;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    check(g < 50, 1, "bus answer");
  endtask

  function automatic int at_least_one(input int x);
    return (x < 1) ? 1 : x;
  endfunction

  // Six separate counts per chip select, zero taken as one
  task automatic program_ce(input int ce);
    int v[6];
    logic [31:0] w, r;
    foreach (v[i]) v[i] = (i % 3 == 1) ? $urandom_range(6) : $urandom_range(3);
    w = {4'(v[0]), 6'(v[1]), 3'(v[2]), 1'b0, 4'(v[3]), 6'(v[4]), 5'h00, 3'(v[5])};
    avs(1'b1, 5'(ce * 4), w, r);
    avs(1'b0, 5'(ce * 4), '0, r);
    check(r, w, "timing readback");
    for (int d = 0; d < 2; d++) begin
      tset[d][ce] = at_least_one(v[3 - 3 * d]);
      tlen[d][ce] = at_least_one(v[4 - 3 * d]);
      thld[d][ce] = at_least_one(v[5 - 3 * d]);
    end
  endtask

  task automatic access(input bit wr, input logic [19:0] a);
    int ce, n_set, n_str, n_hld, g, sl;
    logic [7:0] be;
    logic [63:0] d, e;
    bit bad;
    ce = $urandom_range(3);
    be = 8'($urandom);
    d = {$urandom, $urandom};
    {n_set, n_str, n_hld, g, bad} = '0;
    sl = ($urandom_range(2) == 0) ? tset[wr][ce] + tlen[wr][ce] + 6 : 0;
    e = shadow.exists(a) ? shadow[a] : '0;
    for (int i = 0; i < 8; i++) if (wr && be[i]) e[8*i +: 8] = d[8*i +: 8];
    if (wr) shadow[a] = e;
    @(posedge clk_i);
    slow <= 8'(sl);
    req_valid_i <= 1'b1;
    req_write_i <= wr;
    req_ce_i <= 2'(ce);
    req_addr_i <= a;
    req_be_i <= be;
    req_wdata_i <= d;
    @(posedge clk_i);
    req_valid_i <= 1'b0;
    req_wdata_i <= ~d;
    while (g < 300) begin
      #1;
      if (rsp_valid_o === 1'b1) break;
      if (chip_select_n_o[ce] === 1'b0) begin
        if ((wr ? write_strobe_n_o : read_strobe_n_o) === 1'b0) n_str++;
        else if (n_str == 0) n_set++;
        else n_hld++;
        if (chip_select_n_o !== ~(4'h1 << ce) || mem_addr_bus_o !== a || req_ready_o !== 1'b0
            || byte_lane_n_o !== ~be || output_gate_n_o !== wr || mem_data_oe_o !== wr
            || (wr && mem_data_bus_o !== d)
            || (wr ? read_strobe_n_o : write_strobe_n_o) !== 1'b1) bad = 1'b1;
      end
      @(posedge clk_i);
      g++;
    end
    check(g < 300, 1, "access ends");
    check(n_set, tset[wr][ce], "setup cycles");
    if (sl > 0 && tlen[wr][ce] > 1) begin
      // Ready low well ahead of the sampling point must stretch the strobe
      check(n_str >= tlen[wr][ce] && n_str <= sl + 6, 1, "stretch bound");
      // Synced ready lags the pin by two edges, then the strobe ends two edges later
      if (tset[wr][ce] + tlen[wr][ce] >= 4) begin
        check(n_str, sl + 4 - tset[wr][ce], "stretched");
      end
    end else check(n_str, tlen[wr][ce], "strobe cycles");
    check(n_hld, thld[wr][ce], "hold cycles");
    check(bad, 0, "selects steady");
    if (!wr) check(rsp_rdata_o, e, "read data");
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] r;
    logic [19:0] addr;
    void'($urandom(32'h4faa));
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      avs(1'b0, 5'(c * 4), '0, r);
      check(r, TIMING_RST, "timing reset");
    end
    avs(1'b1, REG_STATUS, 32'hffff_ffff, r);
    avs(1'b0, REG_STATUS, '0, r);
    check(r, 32'h0000_0010, "status read-only");
    avs(1'b1, 5'h14, 32'hffff_ffff, r);
    avs(1'b0, 5'h14, '0, r);
    check(r, 32'h0000_0000, "unmapped");
    avs(1'b1, 5'h00, 32'hffff_ffff, r);
    avs(1'b0, 5'h00, '0, r);
    check(r, TIMING_MASK, "reserved bits");
    for (int k = 0; k < 40; k++) begin
      if (k % 8 == 0) for (int c = 0; c < 4; c++) program_ce(c);
      addr = 20'($urandom_range(7));
      access(1'b1, addr);
      if (k == 0) begin
        // Let the released ready line settle through the synchroniser first
        repeat (2) @(posedge clk_i);
        avs(1'b0, REG_STATUS, '0, r);
        check(r, 32'h0000_0018, "status after write");
      end
      access(1'b0, addr);
      access(1'b0, 20'($urandom_range(15)));
    end
    print_verdict();
  end
  // Watchdog, well beyond the expected few thousand cycles
  initial begin
    #(50_000 * 8);
    err_total++;
    print_verdict();
  end
endmodule
